// ---- hdl/pwc_power_off_wakeup_control.sv ----
// power-off, wake-up and idle sequencer with its always-powered register set
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pwc_defs.svh"
module pwc_power_off_wakeup_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [`PWC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // asynchronous wake sources
  input wire logic [15:0] ext_irq_line,
  input wire logic rtc_alarm,
  input wire logic battery_fault_n,
  // cpu wrapper handshake
  input wire logic idle_ack,
  input wire logic other_irq,
  output logic idle_req,
  // power and reset
  output logic core_supply_enable,
  output logic internal_reset,
  // pin control
  output logic pin_hold,
  output logic [1:0] bus_pullup_ctl,
  output logic [1:0] usb_suspend,
  output logic [2:0] sdram_protect,
  // interrupt requests
  output logic [15:0] ext_irq_req,
  output logic battery_fault_irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pwc_pkg::pwc_state_t state;
  pwc_pkg::pwc_state_t next_state;
  logic [31:0] clock_gate_control;
  logic [1:0] gstat_keep;
  logic gstat2_wake;
  logic [31:0] cfg_lo;
  logic [31:0] cfg_hi;
  logic [15:0] pin_func;
  logic [16:0] ext_mask;
  logic [16:0] wake_cause;
  logic [7:0] wake_cnt;
  logic [15:0] line_s;
  logic rtc_s;
  logic bf_s;
  logic [15:0] hit;
  logic [15:0] wake_lines;
  logic rtc_wake;
  logic wake_any;
  logic any_irq;
  logic wr_ok;
  logic wr_clkgate;
  logic [63:0] cfg_all;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // lines and battery fault idle high; starting there avoids a false edge or fault after reset
  pwc_sync #(.W(18), .INIT(18'h2ffff)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in({battery_fault_n, rtc_alarm, ext_irq_line}),
    .sync_out({bf_s, rtc_s, line_s})
  );

  // ----------------------------------------------------------------
  // trigger detection per line
  // ----------------------------------------------------------------
  assign cfg_all = {cfg_hi, cfg_lo};
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_line
      pwc_trig_detect u_det (
        .core_clk(core_clk),
        .srst(srst),
        .level_in(line_s[gi]),
        .mode(cfg_all[4*gi +: 3]),
        .hit(hit[gi])
      );
    end
  endgenerate

  // a line wakes only with pin function set and mask bit clear
  assign wake_lines = hit & pin_func & ~ext_mask[15:0];
  assign rtc_wake = rtc_s & ~ext_mask[`PWC_EXTMASK_RTC_BIT];
  // battery fault low masks every source
  assign wake_any = ((|wake_lines) | rtc_wake) & bf_s;
  assign any_irq = (|(hit & pin_func)) | rtc_s | other_irq | ~bf_s;
  // software is powered down in off and held in reset during wake
  assign wr_ok = reg_wr & (state != pwc_pkg::PWC_OFF) & (state != pwc_pkg::PWC_WAKE);
  assign wr_clkgate = wr_ok & (reg_addr == `PWC_OFF_CLKGATE);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      pwc_pkg::PWC_RUN: begin
        if (wr_clkgate && reg_wdata[`PWC_CLKGATE_OFF_BIT]) begin
          next_state = pwc_pkg::PWC_OFF;
        end else if (wr_clkgate && reg_wdata[`PWC_CLKGATE_IDLE_BIT]) begin
          next_state = pwc_pkg::PWC_IDLE_REQ;
        end
      end
      pwc_pkg::PWC_IDLE_REQ: begin
        if (idle_ack) begin
          next_state = pwc_pkg::PWC_IDLE;
        end
      end
      pwc_pkg::PWC_IDLE: begin
        if (any_irq) begin
          next_state = pwc_pkg::PWC_RUN;
        end
      end
      pwc_pkg::PWC_OFF: begin
        if (wake_any) begin
          next_state = pwc_pkg::PWC_WAKE;
        end
      end
      pwc_pkg::PWC_WAKE: begin
        if (wake_cnt == 8'h00) begin
          next_state = pwc_pkg::PWC_RUN;
        end
      end
      default: next_state = pwc_pkg::PWC_RUN;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= pwc_pkg::PWC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // length of the internal reset after a wake-up
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_cnt <= 8'h00;
    end else if (state == pwc_pkg::PWC_OFF) begin
      wake_cnt <= 8'((`PWC_WAKE_RST_CYC) - 1);
    end else if (wake_cnt != 8'h00) begin
      wake_cnt <= wake_cnt - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // power, reset and pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      core_supply_enable <= 1'b1;
      internal_reset <= 1'b0;
      pin_hold <= 1'b0;
      idle_req <= 1'b0;
    end else begin
      core_supply_enable <= (next_state != pwc_pkg::PWC_OFF);
      internal_reset <= (next_state == pwc_pkg::PWC_WAKE);
      pin_hold <= (next_state == pwc_pkg::PWC_OFF);
      idle_req <= (next_state == pwc_pkg::PWC_IDLE_REQ) || (next_state == pwc_pkg::PWC_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  // lines serve as plain requests whenever the core is up
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_irq_req <= 16'h0000;
      battery_fault_irq <= 1'b0;
    end else if (next_state == pwc_pkg::PWC_OFF || state == pwc_pkg::PWC_OFF) begin
      ext_irq_req <= 16'h0000;
      battery_fault_irq <= 1'b0;
    end else begin
      ext_irq_req <= hit & pin_func;
      battery_fault_irq <= ~bf_s;
    end
  end

  // ----------------------------------------------------------------
  // clock gate control
  // ----------------------------------------------------------------
  // the wake-up reset returns this core-side register to its reset value
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clock_gate_control <= `PWC_CLKGATE_RST;
    end else if (state == pwc_pkg::PWC_WAKE) begin
      clock_gate_control <= `PWC_CLKGATE_RST;
    end else if (wr_clkgate) begin
      clock_gate_control <= reg_wdata;
    end else if (state == pwc_pkg::PWC_IDLE && any_irq) begin
      clock_gate_control[`PWC_CLKGATE_IDLE_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // misc control, kept across power-off for the sdram hold
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_pullup_ctl <= 2'(`PWC_MISC_RST >> `PWC_MISC_PULLUP_LSB);
      usb_suspend <= 2'(`PWC_MISC_RST >> `PWC_MISC_USB_LSB);
      sdram_protect <= 3'(`PWC_MISC_RST >> `PWC_MISC_PROT_LSB);
    end else if (wr_ok && reg_addr == `PWC_OFF_MISC) begin
      bus_pullup_ctl <= reg_wdata[`PWC_MISC_PULLUP_LSB +: 2];
      usb_suspend <= reg_wdata[`PWC_MISC_USB_LSB +: 2];
      sdram_protect <= reg_wdata[`PWC_MISC_PROT_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // general status registers
  // ----------------------------------------------------------------
  // only the power-on reset clears the saved bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gstat_keep <= 2'h0;
    end else if (wr_ok && reg_addr == `PWC_OFF_GSTAT) begin
      gstat_keep <= reg_wdata[`PWC_GSTAT_KEEP_LSB +: 2];
    end
  end

  // write one clears; a wake-up in the same cycle wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gstat2_wake <= 1'b0;
    end else if (state == pwc_pkg::PWC_OFF && wake_any) begin
      gstat2_wake <= 1'b1;
    end else if (wr_ok && reg_addr == `PWC_OFF_GSTAT2 && reg_wdata[`PWC_GSTAT2_WAKE_BIT]) begin
      gstat2_wake <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_cause <= 17'h00000;
    end else if (state == pwc_pkg::PWC_OFF && wake_any) begin
      wake_cause <= {rtc_wake, wake_lines};
    end
  end

  // ----------------------------------------------------------------
  // wake source configuration
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_lo <= `PWC_EXTCFG_RST;
      cfg_hi <= `PWC_EXTCFG_RST;
      pin_func <= `PWC_PINFUNC_RST;
      ext_mask <= `PWC_EXTMASK_RST;
    end else if (wr_ok) begin
      if (reg_addr == `PWC_OFF_EXTCFG_LO) begin
        cfg_lo <= reg_wdata;
      end else if (reg_addr == `PWC_OFF_EXTCFG_HI) begin
        cfg_hi <= reg_wdata;
      end else if (reg_addr == `PWC_OFF_PINFUNC) begin
        pin_func <= reg_wdata[15:0];
      end else if (reg_addr == `PWC_OFF_EXTMASK) begin
        ext_mask <= reg_wdata[16:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == `PWC_OFF_CLKGATE) begin
      reg_rdata <= clock_gate_control;
    end else if (reg_addr == `PWC_OFF_MISC) begin
      reg_rdata <= {12'h000, sdram_protect, 3'h0, usb_suspend, 10'h000, bus_pullup_ctl};
    end else if (reg_addr == `PWC_OFF_GSTAT) begin
      reg_rdata <= {27'h0000000, gstat_keep, 3'h0};
    end else if (reg_addr == `PWC_OFF_GSTAT2) begin
      reg_rdata <= {29'h00000000, gstat2_wake, 2'h0};
    end else if (reg_addr == `PWC_OFF_EXTCFG_LO) begin
      reg_rdata <= cfg_lo;
    end else if (reg_addr == `PWC_OFF_EXTCFG_HI) begin
      reg_rdata <= cfg_hi;
    end else if (reg_addr == `PWC_OFF_PINFUNC) begin
      reg_rdata <= {16'h0000, pin_func};
    end else if (reg_addr == `PWC_OFF_EXTMASK) begin
      reg_rdata <= {15'h0000, ext_mask};
    end else if (reg_addr == `PWC_OFF_STATUS) begin
      reg_rdata <= {7'h00, wake_cause, 5'h00, state};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_off_supply_low: assert property (state == pwc_pkg::PWC_OFF |-> !core_supply_enable && pin_hold)
    else $error("supply on or pins free in power-off");
  a_off_entry_write: assert property (
    state == pwc_pkg::PWC_RUN && wr_clkgate && reg_wdata[`PWC_CLKGATE_OFF_BIT]
    |=> state == pwc_pkg::PWC_OFF && !core_supply_enable)
    else $error("power-off bit did not start power-off");
  a_wake_reset: assert property (
    state == pwc_pkg::PWC_OFF && wake_any |=> internal_reset ##0 core_supply_enable)
    else $error("wake-up did not raise internal reset");
  a_wake_reset_len: assert property ($rose(internal_reset) |-> internal_reset [*8])
    else $error("wake-up reset too short");
  a_wake_flag_set: assert property (state == pwc_pkg::PWC_OFF && wake_any |=> gstat2_wake)
    else $error("wake flag not set");
  a_keep_bits: assert property ($rose(internal_reset) |-> gstat_keep == $past(gstat_keep, 2))
    else $error("saved status bits lost over wake-up");
  a_no_source_stay: assert property (
    state == pwc_pkg::PWC_OFF && !(|(hit & pin_func & ~ext_mask[15:0])) && !rtc_wake
    |=> state == pwc_pkg::PWC_OFF)
    else $error("left power-off without a wake source");
  a_bf_masks_wake: assert property (state == pwc_pkg::PWC_OFF && !bf_s |=> state == pwc_pkg::PWC_OFF)
    else $error("woke while battery fault asserted");
  a_bf_irq: assert property (state == pwc_pkg::PWC_RUN && !bf_s && next_state == pwc_pkg::PWC_RUN
    |=> battery_fault_irq)
    else $error("battery fault interrupt missing");
  a_idle_wait_ack: assert property (state == pwc_pkg::PWC_IDLE_REQ && !idle_ack
    |=> state == pwc_pkg::PWC_IDLE_REQ && idle_req)
    else $error("idle entered without acknowledge");
  a_line_req_after: assert property ($fell(internal_reset) ##1 (hit[0] && pin_func[0])
    |=> ext_irq_req[0])
    else $error("line not an interrupt again after wake-up");
  c_off_entry: cover property (state == pwc_pkg::PWC_RUN ##1 state == pwc_pkg::PWC_OFF);
  c_wake_line: cover property (state == pwc_pkg::PWC_OFF && (|wake_lines) && bf_s);
  c_wake_rtc: cover property (state == pwc_pkg::PWC_OFF && rtc_wake && bf_s);
  c_idle_cycle: cover property (state == pwc_pkg::PWC_IDLE ##1 state == pwc_pkg::PWC_RUN);

endmodule

// ---- hdl/pwc_defs.svh ----
// register offsets, field positions, reset values and timing counts of the power-off wake-up control
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PWC_ADDR_W 8
`define PWC_OFF_CLKGATE 8'h00
`define PWC_OFF_MISC 8'h04
`define PWC_OFF_GSTAT 8'h08
`define PWC_OFF_GSTAT2 8'h0c
`define PWC_OFF_EXTCFG_LO 8'h10
`define PWC_OFF_EXTCFG_HI 8'h14
`define PWC_OFF_PINFUNC 8'h18
`define PWC_OFF_EXTMASK 8'h1c
`define PWC_OFF_STATUS 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PWC_CLKGATE_IDLE_BIT 2
`define PWC_CLKGATE_OFF_BIT 3
`define PWC_MISC_PULLUP_LSB 0
`define PWC_MISC_USB_LSB 12
`define PWC_MISC_PROT_LSB 17
`define PWC_GSTAT_KEEP_LSB 3
`define PWC_GSTAT2_WAKE_BIT 2
`define PWC_EXTMASK_RTC_BIT 16
`define PWC_STATUS_CAUSE_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PWC_CLKGATE_RST 32'h0007fff0
`define PWC_MISC_RST 32'h00000000
`define PWC_EXTMASK_RST 17'h1ffff
`define PWC_EXTCFG_RST 32'h00000000
`define PWC_PINFUNC_RST 16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PWC_CLK_NS 25
`define PWC_WAKE_RST_NS 1000
`define PWC_WAKE_RST_CYC ((`PWC_WAKE_RST_NS + `PWC_CLK_NS - 1) / `PWC_CLK_NS)

`endif

// ---- hdl/pwc_pkg.sv ----
// types shared by the power-off wake-up control
package pwc_pkg;

  // ----------------------------------------------------------------
  // sequencer states, gray along run -> off -> wake and run -> idle
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PWC_RUN = 3'h0,
    PWC_IDLE_REQ = 3'h1,
    PWC_IDLE = 3'h3,
    PWC_OFF = 3'h4,
    PWC_WAKE = 3'h6
  } pwc_state_t;

  // ----------------------------------------------------------------
  // trigger select of one external interrupt line
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWC_TRIG_LEVEL = 2'h0,
    PWC_TRIG_FALL = 2'h1,
    PWC_TRIG_RISE = 2'h2,
    PWC_TRIG_BOTH = 2'h3
  } pwc_trig_t;

endpackage

// ---- hdl/pwc_sync.sv ----
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module pwc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta <= INIT;
      sync_out <= INIT;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- hdl/pwc_trig_detect.sv ----
// level or edge detector for one synchronised external interrupt line
`timescale 1ns/1ps
module pwc_trig_detect (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // line and its trigger select
  input wire logic level_in,
  input wire logic [2:0] mode,
  output logic hit
);

  logic prev;
  logic prev_ok;

  // the first cycle after reset has no history, so no edge is seen there
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev <= 1'b0;
      prev_ok <= 1'b0;
    end else begin
      prev <= level_in;
      prev_ok <= 1'b1;
    end
  end

  always_comb begin
    case (pwc_pkg::pwc_trig_t'(mode[2:1]))
      pwc_pkg::PWC_TRIG_LEVEL: hit = (level_in == mode[0]);
      pwc_pkg::PWC_TRIG_FALL: hit = prev_ok & prev & ~level_in;
      pwc_pkg::PWC_TRIG_RISE: hit = prev_ok & ~prev & level_in;
      default: hit = prev_ok & (prev ^ level_in);
    endcase
  end

endmodule

// ---- verification/pwc_far_side.sv ----
// far-side model: core supply regulator and the asynchronous wake sources
`timescale 1ns/1ps
module pwc_far_side (
  // clock
  input wire logic core_clk,
  // wanted source levels and how slowly they follow
  input wire logic [15:0] want_lines,
  input wire logic want_rtc,
  input wire logic want_bat_n,
  input wire logic [3:0] lag,
  // regulator
  input wire logic core_supply_enable,
  output logic supply_up,
  // wake sources
  output logic [15:0] ext_irq_line,
  output logic rtc_alarm,
  output logic battery_fault_n
);
  logic [3:0] cnt = 4'h0;
  logic [2:0] ramp = 3'h0;
  initial begin
    {ext_irq_line, rtc_alarm, battery_fault_n, supply_up} = {16'hffff, 3'b011};
  end
  // a source moves on the lag+1th clock edge after it is asked, so slow sources are seen too
  always @(posedge core_clk) begin
    if ({want_lines, want_rtc, want_bat_n} !== {ext_irq_line, rtc_alarm, battery_fault_n}) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lag) begin
        {ext_irq_line, rtc_alarm, battery_fault_n} <= {want_lines, want_rtc, want_bat_n};
        cnt <= 4'h0;
      end
    end
  end
  // supplies drop at once and need a few cycles to ramp back
  always @(posedge core_clk) begin
    if (!core_supply_enable) begin
      ramp <= 3'h0;
      supply_up <= 1'b0;
    end else if (ramp != 3'h7) begin
      ramp <= ramp + 3'h1;
    end else begin
      supply_up <= 1'b1;
    end
  end
endmodule

// ---- verification/power_off_wakeup_control_tb.sv ----
// self-checking bench for the power-off wake-up control
`timescale 1ns/1ps
`include "pwc_defs.svh"
module power_off_wakeup_control_tb;
  logic core_clk, srst, reg_wr, reg_rd, idle_ack, other_irq, rd_seen;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] ext_irq_line, want_lines, ext_irq_req;
  logic rtc_alarm, battery_fault_n, want_rtc, want_bat_n, supply_up;
  logic idle_req, core_supply_enable, internal_reset, pin_hold, battery_fault_irq;
  logic [1:0] bus_pullup_ctl, usb_suspend;
  logic [2:0] sdram_protect;
  logic [3:0] lag;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0] adr_q[$];
  int err_count, compares;
  integer seed;

  pwc_power_off_wakeup_control DUT (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq_line(ext_irq_line), .rtc_alarm(rtc_alarm), .battery_fault_n(battery_fault_n),
    .idle_ack(idle_ack), .other_irq(other_irq), .idle_req(idle_req),
    .core_supply_enable(core_supply_enable), .internal_reset(internal_reset), .pin_hold(pin_hold),
    .bus_pullup_ctl(bus_pullup_ctl), .usb_suspend(usb_suspend), .sdram_protect(sdram_protect),
    .ext_irq_req(ext_irq_req), .battery_fault_irq(battery_fault_irq));
  pwc_far_side far (.core_clk(core_clk), .want_lines(want_lines), .want_rtc(want_rtc),
    .want_bat_n(want_bat_n), .lag(lag), .core_supply_enable(core_supply_enable),
    .supply_up(supply_up), .ext_irq_line(ext_irq_line), .rtc_alarm(rtc_alarm),
    .battery_fault_n(battery_fault_n));

  // ----------------------------------------------------------------
  // clock, compare and bus tasks
  // ----------------------------------------------------------------
  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    compares++;
    if ((reg_rdata & m) !== (e & m)) begin
      err_count++;
      $display("unexpected reg %h: expected %h seen %h", a, e & m, reg_rdata & m);
    end
  endtask
  task automatic chk_pin(input string what, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    adr_q.push_back(a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
  endtask
  // bounded wait for the internal reset to reach a level
  task automatic wait_rst(input logic lvl, input int lim);
    int n;
    n = 0;
    while (internal_reset !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    if (internal_reset !== lvl) begin
      err_count++;
      $display("unexpected internal_reset: expected %b seen %b", lvl, internal_reset);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      chk_reg(adr_q.pop_front(), exp_q.pop_front(), msk_q.pop_front());
    end
  end

  initial begin
    tick(30000);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int ln;
    logic [31:0] v;
    logic [1:0] keep;
    logic [2:0] mode_tab[5];
    logic start_tab[5];
    mode_tab = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
    start_tab = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    seed = 32'he1e2b350;
    {srst, reg_wr, reg_rd, idle_ack, other_irq, want_rtc, want_bat_n} = 7'h41;
    {reg_addr, reg_wdata, want_lines, lag} = {8'h00, 32'h0, 16'hffff, 4'h0};
    {err_count, compares} = {32'h0, 32'h0};
    tick(16);
    srst <= 1'b0;
    tick(1);
    rd_reg(`PWC_OFF_CLKGATE, `PWC_CLKGATE_RST, 32'hffffffff);
    rd_reg(`PWC_OFF_EXTMASK, 32'h1ffff, 32'h1ffff);
    rd_reg(8'h24, 32'h0, 32'hffffffff);
    v = 32'($random(seed));
    keep = v[5:4];
    wr_reg(`PWC_OFF_MISC, 32'h000e3000 | {30'h0, v[1:0]});
    chk_pin("misc pins", {1'b1, 3'h7}, {v[1:0] == bus_pullup_ctl, sdram_protect});
    chk_pin("usb", 4'h3, {2'h0, usb_suspend});
    wr_reg(`PWC_OFF_GSTAT, {27'h0, keep, 3'h0});
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      ln = $unsigned($random(seed)) % 16;
      lag <= 4'($unsigned($random(seed)) % 8);
      want_lines[ln] <= start_tab[i];
      v = 32'(mode_tab[i]) << (4 * (ln % 8));
      wr_reg(ln < 8 ? `PWC_OFF_EXTCFG_LO : `PWC_OFF_EXTCFG_HI, v);
      wr_reg(`PWC_OFF_PINFUNC, 32'h1 << ln);
      wr_reg(`PWC_OFF_EXTMASK, 32'h1ffff & ~(32'h1 << ln));
      // sdram self-refresh lies outside this block; this wait stands for it before entry
      tick(12);
      wr_reg(`PWC_OFF_CLKGATE, 32'h8);
      chk_pin("off pins", 4'h4, {core_supply_enable, pin_hold, 2'(ext_irq_req[ln])});
      want_lines[ln] <= ~start_tab[i];
      wait_rst(1'b1, 30);
      chk_pin("wake", 4'h3, {2'h0, internal_reset, core_supply_enable});
      wait_rst(1'b0, 60);
      chk_pin("supply", 4'h1, {3'h0, supply_up});
      rd_reg(`PWC_OFF_GSTAT2, 32'h4, 32'h4);
      rd_reg(`PWC_OFF_GSTAT, {27'h0, keep, 3'h0}, 32'h18);
      rd_reg(`PWC_OFF_CLKGATE, `PWC_CLKGATE_RST, 32'hffffffff);
      rd_reg(`PWC_OFF_STATUS, 32'h100 << ln, 32'h01ffff00);
      wr_reg(`PWC_OFF_GSTAT2, 32'h4);
      rd_reg(`PWC_OFF_GSTAT2, 32'h0, 32'h4);
      wr_reg(`PWC_OFF_PINFUNC, 32'h1 << ln);
      tick(3);
      if (i < 2) begin
        chk_pin("line req", 4'h1, {3'h0, ext_irq_req[ln]});
      end
      want_lines[ln] <= 1'b1;
      tick(12);
    end
    $display("test wake modes done");
    // lines active without pin function, then rtc under battery fault
    wr_reg(`PWC_OFF_EXTCFG_LO, 32'h0);
    wr_reg(`PWC_OFF_PINFUNC, 32'h0);
    wr_reg(`PWC_OFF_EXTMASK, 32'h0);
    wr_reg(`PWC_OFF_CLKGATE, 32'h8);
    want_lines <= 16'h0000;
    tick(20);
    chk_pin("no pin wake", 4'h0, {2'h0, internal_reset, core_supply_enable});
    want_bat_n <= 1'b0;
    want_rtc <= 1'b1;
    tick(20);
    chk_pin("fault off", 4'h1, {internal_reset, battery_fault_irq, 1'b0, pin_hold});
    want_bat_n <= 1'b1;
    wait_rst(1'b1, 30);
    chk_pin("rtc wake", 4'h1, {3'h0, internal_reset});
    wait_rst(1'b0, 60);
    rd_reg(`PWC_OFF_STATUS, 32'h01000000, 32'h01ffff00);
    want_rtc <= 1'b0;
    want_lines <= 16'hffff;
    wr_reg(`PWC_OFF_MISC, 32'h0);
    chk_pin("released", 4'h0, {1'b0, sdram_protect});
    want_bat_n <= 1'b0;
    tick(14);
    chk_pin("fault irq", 4'h1, {3'h0, battery_fault_irq});
    want_bat_n <= 1'b1;
    tick(14);
    chk_pin("fault gone", 4'h0, {3'h0, battery_fault_irq});
    $display("test refusals done");
    // the pll stays on and slow mode is never entered, so no pll switch is ever made
    wr_reg(`PWC_OFF_CLKGATE, `PWC_CLKGATE_RST | 32'h4);
    tick(5);
    chk_pin("idle req", 4'h1, {3'h0, idle_req});
    rd_reg(`PWC_OFF_STATUS, 32'(pwc_pkg::PWC_IDLE_REQ), 32'h7);
    idle_ack <= 1'b1;
    tick(3);
    rd_reg(`PWC_OFF_STATUS, 32'(pwc_pkg::PWC_IDLE), 32'h7);
    other_irq <= 1'b1;
    tick(1);
    {other_irq, idle_ack} <= 2'b00;
    tick(3);
    chk_pin("idle end", 4'h0, {3'h0, idle_req});
    rd_reg(`PWC_OFF_CLKGATE, `PWC_CLKGATE_RST, 32'hffffffff);
    tick(2);
    $display("test idle done");
    report_and_stop();
  end
endmodule
